// ==== rtl/erx_pkg.sv ====
// Purpose: Shared constants and types for the receive/management/wake block
// Assumes: MII nibble stream, low nibble of each byte first
// Notes:   Frame, CRC, address, wake, sync-width and state constants are named here
package erx_pkg;

  // ------------------------------------------------------------------
  // Frame delimiters
  // ------------------------------------------------------------------
  localparam logic [3:0]  PRE_NIB      = 4'h5;         // Preamble nibble
  localparam logic [3:0]  SFD_NIB      = 4'hD;         // Delimiter nibble
  localparam logic [7:0]  BCAST_BYTE   = 8'hFF;        // Broadcast / sync byte

  // ------------------------------------------------------------------
  // Frame check sequence, reflected form
  // ------------------------------------------------------------------
  localparam logic [31:0] CRC_INIT     = 32'hFFFFFFFF; // Seed
  localparam logic [31:0] CRC_POLY     = 32'hEDB88320; // Reflected polynomial
  localparam logic [31:0] CRC_RESIDUE  = 32'hDEBB20E3; // Good-frame remainder

  // ------------------------------------------------------------------
  // Address and wake-up pattern geometry
  // ------------------------------------------------------------------
  localparam logic [2:0]  ADDR_LAST    = 3'h5;         // Last address byte
  localparam logic [2:0]  ADDR_DONE    = 3'h6;         // Address fully seen
  localparam int          MC_BIT       = 0;            // Group bit of byte 0
  localparam logic [2:0]  WAKE_SYNC    = 3'h6;         // Sync bytes needed
  localparam logic [3:0]  WAKE_REP_END = 4'hF;         // Last address repeat
  localparam int          ADDR_W       = 48;           // Station address width
  localparam int          SYNC_RX_W    = 53;           // Bits into link domain
  localparam int          SYNC_MC_W    = 3;            // Bits into mclk domain

  // ------------------------------------------------------------------
  // Receiver states
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF  = 3'b000,                                  // Receiver disabled
    ST_IDLE = 3'b001,                                  // Waiting for a frame
    ST_PRE  = 3'b010,                                  // In preamble
    ST_DATA = 3'b011,                                  // Frame body
    ST_DROP = 3'b100                                   // Discard to frame end
  } erx_state_type;

endpackage : erx_pkg

// ==== rtl/erx_sync_if.sv ====
// Purpose: Carrier for a group of bits crossing into a clock domain
// Assumes: Width matches the synchroniser it is attached to
// Notes:   async_in is driven by the user, sync_out by the synchroniser
`timescale 1ns/100ps
interface erx_sync_if #(parameter int W = 1);
  logic [W-1:0] async_in;                              // Foreign-domain bits
  logic [W-1:0] sync_out;                              // Local-domain copy
  modport sync_side (input async_in, output sync_out);
  modport user_side (output async_in, input sync_out);
endinterface : erx_sync_if

// ==== rtl/erx_sync.sv ====
// Purpose: Two-flop level synchroniser for a group of bits
// Assumes: Multi-bit groups are quasi-static or single-bit toggles
// Notes:   First stage is read only by the second stage
`timescale 1ns/100ps
module erx_sync #(
  parameter int W = 1
) (
  input wire logic       clk,
  erx_sync_if.sync_side  sif
);

  // ------------------------------------------------------------------
  // Synchroniser stages
  // ------------------------------------------------------------------
  logic [W-1:0] meta_ff;                               // First stage
  logic [W-1:0] hold_ff;                               // Second stage

  // Shift foreign bits through two stages
  always_ff @(posedge clk) begin
    meta_ff <= sif.async_in;
    hold_ff <= meta_ff;
  end

  assign sif.sync_out = hold_ff;

endmodule : erx_sync

// ==== rtl/erx_mac_rx.sv ====
// Purpose: Receive path, management pin control and wake-up detection
// Assumes: rx_clk is the PHY receive clock; station address quasi-static
// Notes:   Link logic on rx_clk, control and status on mclk
// Behaviour
// - Receive enable moves receiver to idle
// - Frame processing starts after delimiter follows preamble
// - Accept own, broadcast, multicast or promiscuous frames
// - Check frame CRC, report result status
// - Rearm after frame only while enable set
// - Management frame field order set by software
// - Start and opcode codes set by software
// - Write turnaround driven, read turnaround released
// - Sixteen data bits, driven or sampled
// - Pin bits give bit write, read, release
// - Wake detection only while enabled, separate interrupt enable
// - Wake detection raises interrupt and wake pin
// - Wake ignores destination, needs embedded address match
// - Wake status stays until soft reset
// - Invalid preamble or delimiter discards frame
`timescale 1ns/100ps
module erx_mac_rx (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        rx_clk,
  input  wire logic [3:0]  mii_rxd,
  input  wire logic        mii_rx_dv,
  input  wire logic        rx_enable_bit,
  input  wire logic        promiscuous_mode,
  input  wire logic        multicast_enable,
  input  wire logic [47:0] station_addr,
  input  wire logic        soft_reset_bit,
  input  wire logic        wake_detect_enable,
  input  wire logic        wake_detect_irq_enable,
  input  wire logic        pir_mdc_bit,
  input  wire logic        pir_mdo_bit,
  input  wire logic        pir_mmd_bit,
  input  wire logic        mdio_i,
  output logic             pir_mdi_bit,
  output logic             mdc,
  output logic             mdio_o,
  output logic             mdio_oe_n,
  output logic [7:0]       rx_data,
  output logic             rx_data_valid,
  output logic             rx_frame_done,
  output logic             rx_frame_ok,
  output logic             rx_crc_error,
  output logic             wake_irq,
  output logic             wake_pin
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Pick address byte i, byte 0 is the first on the wire
  function automatic logic [7:0] addr_byte(input logic [47:0] a,
                                           input logic [2:0]  i);
    logic [5:0] sh;
    sh = {3'(erx_pkg::ADDR_LAST - i), 3'h0};
    addr_byte = 8'(a >> sh);
  endfunction : addr_byte

  // Advance reflected CRC by one byte
  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0]  d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ erx_pkg::CRC_POLY) : (r >> 1);
    end
    crc_byte = r;
  endfunction : crc_byte

  // ------------------------------------------------------------------
  // Crossings
  // ------------------------------------------------------------------
  erx_sync_if #(.W(erx_pkg::SYNC_RX_W)) rx_sif ();     // Into link domain
  erx_sync_if #(.W(erx_pkg::SYNC_MC_W)) mc_sif ();     // Into mclk domain

  logic              run_s;                            // Link domain may run
  logic              rst_rx;                           // Link domain reset
  logic              rx_en_s;                          // Synced enable
  logic              prom_s;                           // Synced promiscuous
  logic              mc_en_s;                          // Synced multicast
  logic              wk_en_s;                          // Synced wake enable
  logic [47:0]       sta_s;                            // Synced address
  logic              btgl_ff;                          // Byte event toggle
  logic              ftgl_ff;                          // Frame event toggle

  // Control into link domain; soft reset also restarts link logic
  assign rx_sif.async_in = {station_addr, wake_detect_enable,
                            multicast_enable, promiscuous_mode,
                            rx_enable_bit, rst_n & ~soft_reset_bit};
  assign {sta_s, wk_en_s, mc_en_s, prom_s, rx_en_s, run_s} =
         rx_sif.sync_out;
  assign rst_rx = ~run_s;

  // Events and the pin input into mclk domain
  assign mc_sif.async_in = {mdio_i, ftgl_ff, btgl_ff};

  erx_sync #(.W(erx_pkg::SYNC_RX_W)) u_sync_rx (
    .clk (rx_clk),
    .sif (rx_sif)
  );

  erx_sync #(.W(erx_pkg::SYNC_MC_W)) u_sync_mc (
    .clk (mclk),
    .sif (mc_sif)
  );

  // ------------------------------------------------------------------
  // Link-domain receiver
  // ------------------------------------------------------------------
  erx_pkg::erx_state_type st_ff, nxt_st;               // Receiver state
  logic [3:0]  rxd_ff;                                 // Registered nibble
  logic        dv_ff;                                  // Registered valid
  logic [3:0]  lo_ff,   nxt_lo;                        // Low nibble held
  logic        half_ff, nxt_half;                      // Low nibble present
  logic [2:0]  idx_ff,  nxt_idx;                       // Address byte count
  logic        mst_ff,  nxt_mst;                       // Own address so far
  logic        mbc_ff,  nxt_mbc;                       // Broadcast so far
  logic        mc_ff,   nxt_mc;                        // Group bit seen
  logic        acc_ff,  nxt_acc;                       // Frame accepted
  logic [31:0] crc_ff,  nxt_crc;                       // Running CRC
  logic [7:0]  byte_ff, nxt_byte;                      // Delivered byte
  logic        nxt_btgl, nxt_ftgl;                     // Event toggles
  logic        rok_ff,  nxt_rok;                       // Result good
  logic        rerr_ff, nxt_rerr;                      // Result CRC error
  logic        rwk_ff,  nxt_rwk;                       // Result wake
  logic [2:0]  wrun_ff, nxt_wrun;                      // Sync bytes seen
  logic [2:0]  widx_ff, nxt_widx;                      // Wake address byte
  logic [3:0]  wrep_ff, nxt_wrep;                      // Wake repeat count
  logic        whit_ff, nxt_whit;                      // Wake pattern found
  logic [7:0]  byte_in;                                // Assembled byte
  logic [7:0]  sta_b;                                  // Expected DA byte
  logic [7:0]  wk_b;                                   // Expected wake byte

  // Next-state for the receiver
  always_comb begin
    nxt_st = st_ff;      nxt_lo = lo_ff;      nxt_half = half_ff;
    nxt_idx = idx_ff;    nxt_mst = mst_ff;    nxt_mbc = mbc_ff;
    nxt_mc = mc_ff;      nxt_acc = acc_ff;    nxt_crc = crc_ff;
    nxt_byte = byte_ff;  nxt_btgl = btgl_ff;  nxt_ftgl = ftgl_ff;
    nxt_rok = rok_ff;    nxt_rerr = rerr_ff;  nxt_rwk = rwk_ff;
    nxt_wrun = wrun_ff;  nxt_widx = widx_ff;  nxt_wrep = wrep_ff;
    nxt_whit = whit_ff;
    byte_in = {rxd_ff, lo_ff};
    sta_b   = addr_byte(sta_s, idx_ff);
    wk_b    = addr_byte(sta_s, widx_ff);
    case (st_ff)
      // Disabled until software enables reception
      erx_pkg::ST_OFF: begin
        if (rx_en_s) nxt_st = erx_pkg::ST_IDLE;
      end
      // Frame must open with preamble
      erx_pkg::ST_IDLE: begin
        if (!rx_en_s) nxt_st = erx_pkg::ST_OFF;
        else if (dv_ff) begin
          nxt_st = (rxd_ff == erx_pkg::PRE_NIB) ? erx_pkg::ST_PRE
                                                : erx_pkg::ST_DROP;
        end
      end
      // Wait for delimiter; a nibble other than preamble discards, loss of valid returns to idle
      erx_pkg::ST_PRE: begin
        if (!dv_ff) nxt_st = erx_pkg::ST_IDLE;
        else if (rxd_ff == erx_pkg::SFD_NIB) begin
          nxt_st = erx_pkg::ST_DATA;
          nxt_half = 1'b0;  nxt_idx = 3'h0;   nxt_mst = 1'b1;
          nxt_mbc = 1'b1;   nxt_mc = 1'b0;    nxt_acc = 1'b0;
          nxt_crc = erx_pkg::CRC_INIT;        nxt_wrun = 3'h0;
          nxt_widx = 3'h0;  nxt_wrep = 4'h0;  nxt_whit = 1'b0;
        end else if (rxd_ff != erx_pkg::PRE_NIB) begin
          nxt_st = erx_pkg::ST_DROP;
        end
      end
      // Frame body: bytes, filter, CRC, wake pattern
      erx_pkg::ST_DATA: begin
        if (!dv_ff) begin
          nxt_rok  = acc_ff && (crc_ff == erx_pkg::CRC_RESIDUE);
          nxt_rerr = acc_ff && (crc_ff != erx_pkg::CRC_RESIDUE);
          nxt_rwk  = whit_ff && wk_en_s;
          if (acc_ff || nxt_rwk) nxt_ftgl = ~ftgl_ff;
          nxt_st = rx_en_s ? erx_pkg::ST_IDLE : erx_pkg::ST_OFF;
        end else if (!half_ff) begin
          nxt_lo = rxd_ff;
          nxt_half = 1'b1;
        end else begin
          nxt_half = 1'b0;
          nxt_crc = crc_byte(crc_ff, byte_in);
          if (idx_ff != erx_pkg::ADDR_DONE) begin
            nxt_idx = idx_ff + 3'h1;
            nxt_mst = mst_ff && (byte_in == sta_b);
            nxt_mbc = mbc_ff && (byte_in == erx_pkg::BCAST_BYTE);
            if (idx_ff == 3'h0) nxt_mc = byte_in[erx_pkg::MC_BIT];
            if (idx_ff == erx_pkg::ADDR_LAST) begin
              nxt_acc = prom_s | nxt_mst | nxt_mbc
                        | (mc_en_s & nxt_mc);
            end
          end else if (acc_ff) begin
            nxt_byte = byte_in;
            nxt_btgl = ~btgl_ff;
          end
          // Wake pattern, independent of destination address
          if (!whit_ff) begin
            if (wrun_ff == erx_pkg::WAKE_SYNC) begin
              if (byte_in == wk_b) begin
                nxt_widx = widx_ff + 3'h1;
                if (widx_ff == erx_pkg::ADDR_LAST) begin
                  nxt_widx = 3'h0;
                  nxt_wrep = wrep_ff + 4'h1;
                  if (wrep_ff == erx_pkg::WAKE_REP_END) nxt_whit = 1'b1;
                end
              end else if (!(byte_in == erx_pkg::BCAST_BYTE &&
                             widx_ff == 3'h0 && wrep_ff == 4'h0)) begin
                nxt_widx = 3'h0;
                nxt_wrep = 4'h0;
                nxt_wrun = (byte_in == erx_pkg::BCAST_BYTE) ? 3'h1 : 3'h0;
              end
            end else begin
              nxt_wrun = (byte_in == erx_pkg::BCAST_BYTE) ?
                         wrun_ff + 3'h1 : 3'h0;
            end
          end
        end
      end
      // Discard until the line goes quiet
      erx_pkg::ST_DROP: begin
        if (!dv_ff) nxt_st = rx_en_s ? erx_pkg::ST_IDLE : erx_pkg::ST_OFF;
      end
      default: nxt_st = erx_pkg::ST_OFF;
    endcase
  end

  // Register the receiver on the link clock
  always_ff @(posedge rx_clk) begin
    rxd_ff <= mii_rxd;
    dv_ff  <= mii_rx_dv;
    if (rst_rx) begin
      st_ff <= erx_pkg::ST_OFF;  lo_ff <= 4'h0;    half_ff <= 1'b0;
      idx_ff <= 3'h0;            mst_ff <= 1'b0;   mbc_ff <= 1'b0;
      mc_ff <= 1'b0;             acc_ff <= 1'b0;   crc_ff <= 32'h0;
      byte_ff <= 8'h00;          btgl_ff <= 1'b0;  ftgl_ff <= 1'b0;
      rok_ff <= 1'b0;            rerr_ff <= 1'b0;  rwk_ff <= 1'b0;
      wrun_ff <= 3'h0;           widx_ff <= 3'h0;  wrep_ff <= 4'h0;
      whit_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;           lo_ff <= nxt_lo;     half_ff <= nxt_half;
      idx_ff <= nxt_idx;         mst_ff <= nxt_mst;   mbc_ff <= nxt_mbc;
      mc_ff <= nxt_mc;           acc_ff <= nxt_acc;   crc_ff <= nxt_crc;
      byte_ff <= nxt_byte;       btgl_ff <= nxt_btgl; ftgl_ff <= nxt_ftgl;
      rok_ff <= nxt_rok;         rerr_ff <= nxt_rerr; rwk_ff <= nxt_rwk;
      wrun_ff <= nxt_wrun;       widx_ff <= nxt_widx; wrep_ff <= nxt_wrep;
      whit_ff <= nxt_whit;
    end
  end

  // ------------------------------------------------------------------
  // mclk-domain status and management pins
  // ------------------------------------------------------------------
  logic [1:0]  ev_ff;                                  // Last seen toggles
  logic [7:0]  data_ff,  nxt_data;                     // Output byte
  logic        val_ff,   nxt_val;                      // Byte strobe
  logic        done_ff,  nxt_done;                     // Frame strobe
  logic        ok_ff,    nxt_ok;                       // Good frame status
  logic        err_ff,   nxt_err;                      // CRC error status
  logic        wpin_ff,  nxt_wpin;                     // Wake pin
  logic        wirq_ff,  nxt_wirq;                     // Wake interrupt
  logic        mdc_ff, mdo_ff, oen_ff, mdi_ff;         // Pin registers
  logic        byte_ev, frame_ev, wake_set;            // Decoded events

  // Next values; toggles dropped by a soft link restart are ignored
  always_comb begin
    byte_ev  = (mc_sif.sync_out[0] ^ ev_ff[0]) & ~soft_reset_bit;
    frame_ev = (mc_sif.sync_out[1] ^ ev_ff[1]) & ~soft_reset_bit;
    wake_set = frame_ev && rwk_ff && wake_detect_enable;
    nxt_data = byte_ev ? byte_ff : data_ff;
    nxt_val  = byte_ev;
    nxt_done = frame_ev;
    nxt_ok   = frame_ev ? rok_ff  : (ok_ff  & ~soft_reset_bit);
    nxt_err  = frame_ev ? rerr_ff : (err_ff & ~soft_reset_bit);
    nxt_wpin = wake_set | (wpin_ff & ~soft_reset_bit);
    nxt_wirq = (wake_set & wake_detect_irq_enable)
               | (wirq_ff & ~soft_reset_bit);
  end

  // Register status and management pins on mclk
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ev_ff <= 2'h0;    data_ff <= 8'h00; val_ff <= 1'b0;
      done_ff <= 1'b0;  ok_ff <= 1'b0;    err_ff <= 1'b0;
      wpin_ff <= 1'b0;  wirq_ff <= 1'b0;  mdc_ff <= 1'b0;
      mdo_ff <= 1'b0;   oen_ff <= 1'b1;   mdi_ff <= 1'b0;
    end else begin
      ev_ff <= mc_sif.sync_out[1:0];
      data_ff <= nxt_data; val_ff <= nxt_val;   done_ff <= nxt_done;
      ok_ff <= nxt_ok;     err_ff <= nxt_err;   wpin_ff <= nxt_wpin;
      wirq_ff <= nxt_wirq;
      mdc_ff <= pir_mdc_bit;
      mdo_ff <= pir_mdo_bit;
      oen_ff <= ~pir_mmd_bit;
      mdi_ff <= mc_sif.sync_out[2];
    end
  end

  assign rx_data       = data_ff;
  assign rx_data_valid = val_ff;
  assign rx_frame_done = done_ff;
  assign rx_frame_ok   = ok_ff;
  assign rx_crc_error  = err_ff;
  assign wake_pin      = wpin_ff;
  assign wake_irq      = wirq_ff;
  assign mdc           = mdc_ff;
  assign mdio_o        = mdo_ff;
  assign mdio_oe_n     = oen_ff;
  assign pir_mdi_bit   = mdi_ff;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  a_enable_to_idle: assert property (@(posedge rx_clk) disable iff (rst_rx)
    st_ff == erx_pkg::ST_OFF && rx_en_s |=> st_ff == erx_pkg::ST_IDLE)
    else $error("enable did not reach idle");
  a_sfd_start: assert property (@(posedge rx_clk) disable iff (rst_rx)
    st_ff == erx_pkg::ST_PRE && dv_ff && rxd_ff == erx_pkg::SFD_NIB
    |=> st_ff == erx_pkg::ST_DATA && crc_ff == erx_pkg::CRC_INIT)
    else $error("delimiter did not open frame");
  a_bad_pre_drop: assert property (@(posedge rx_clk) disable iff (rst_rx)
    st_ff == erx_pkg::ST_PRE && dv_ff && rxd_ff != erx_pkg::SFD_NIB
    && rxd_ff != erx_pkg::PRE_NIB |=> st_ff == erx_pkg::ST_DROP)
    else $error("bad preamble not discarded");
  a_end_rearm: assert property (@(posedge rx_clk) disable iff (rst_rx)
    st_ff == erx_pkg::ST_DATA && !dv_ff
    |=> st_ff == ($past(rx_en_s) ? erx_pkg::ST_IDLE : erx_pkg::ST_OFF))
    else $error("wrong state after frame");
  a_status_excl: assert property (@(posedge mclk) disable iff (!rst_n)
    !(ok_ff && err_ff))
    else $error("good and error status together");
  a_valid_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
    val_ff |=> !val_ff)
    else $error("byte strobe longer than one cycle");
  a_wake_pin_set: assert property (@(posedge mclk) disable iff (!rst_n)
    frame_ev && rwk_ff && wake_detect_enable |=> wpin_ff)
    else $error("wake pin not raised");
  a_irq_gated: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(wirq_ff) |-> $past(wake_detect_irq_enable) && wpin_ff)
    else $error("wake interrupt without enable");
  a_release_pin: assert property (@(posedge mclk) disable iff (!rst_n)
    !pir_mmd_bit |=> oen_ff)
    else $error("pin not released");
  a_mdi_path: assert property (@(posedge mclk) disable iff (!rst_n)
    ##3 mdi_ff == $past(mdio_i, 3))
    else $error("sampled input wrong");

endmodule : erx_mac_rx

// ==== test/erx_phy_model.sv ====
// Purpose: Far-side transceiver model driving the receive nibble stream
// Assumes: Receive clock runs freely, unrelated in phase to mclk
// Notes:   Bytes go out low nibble first; the line is inverted when idle
`timescale 1ns/100ps
module erx_phy_model (
  output logic       rx_clk,
  output logic [3:0] mii_rxd,
  output logic       mii_rx_dv
);
  // Receive clock, 64 ns period with a phase offset
  initial begin
    rx_clk = 1'b0;
    #7;
    forever #32 rx_clk = ~rx_clk;
  end
  initial begin
    mii_rx_dv = 1'b0;
    mii_rxd   = 4'hA;
  end
  // Preamble, delimiter nibble, then the body bytes
  task automatic send(input logic [7:0] q[$], input logic [3:0] sfd);
    @(negedge rx_clk);
    mii_rx_dv <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      mii_rxd <= (i == 15) ? sfd : 4'h5;
      @(negedge rx_clk);
    end
    foreach (q[i]) for (int h = 0; h < 2; h++) begin
      mii_rxd <= h ? q[i][7:4] : q[i][3:0];
      @(negedge rx_clk);
    end
    mii_rx_dv <= 1'b0;
    mii_rxd   <= ~mii_rxd;
    @(negedge rx_clk);
  endtask : send
endmodule : erx_phy_model

// ==== test/tb_top.sv ====
// Purpose: Self-checking bench for receive, pin control and wake logic
// Assumes: Controls change at the falling edge of mclk
// Notes:   Random payloads from a fixed seed
`timescale 1ns/100ps
module tb_top;
  logic mclk, rst_n, rx_clk, mii_rx_dv, rx_enable_bit, promiscuous_mode;
  logic multicast_enable, soft_reset_bit, wake_detect_enable, phy_b;
  logic wake_detect_irq_enable, pir_mdc_bit, pir_mdo_bit, pir_mmd_bit;
  logic mdio_i, pir_mdi_bit, mdc, mdio_o, mdio_oe_n, rx_data_valid;
  logic rx_frame_done, rx_frame_ok, rx_crc_error, wake_irq, wake_pin;
  logic [3:0] mii_rxd;
  logic [7:0] rx_data, got[$];
  logic [47:0] station_addr;
  int seed, dones, miscompares, tests_run;
  // Wire level: design drives when enable low, else the far side
  assign mdio_i = mdio_oe_n ? phy_b : mdio_o;
  erx_phy_model i_phy (.rx_clk, .mii_rxd, .mii_rx_dv);
  erx_mac_rx i_dut (.mclk, .rst_n, .rx_clk, .mii_rxd, .mii_rx_dv,
    .rx_enable_bit, .promiscuous_mode, .multicast_enable, .station_addr,
    .soft_reset_bit, .wake_detect_enable, .wake_detect_irq_enable,
    .pir_mdc_bit, .pir_mdo_bit, .pir_mmd_bit, .mdio_i, .pir_mdi_bit, .mdc,
    .mdio_o, .mdio_oe_n, .rx_data, .rx_data_valid, .rx_frame_done,
    .rx_frame_ok, .rx_crc_error, .wake_irq, .wake_pin);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Collect delivered bytes and frame ends
  always @(posedge mclk) begin
    if (rx_data_valid === 1'b1) got.push_back(rx_data);
    if (rx_frame_done === 1'b1) dones++;
  end
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // Reflected frame check sequence over a byte queue
  function automatic logic [31:0] fcs(input logic [7:0] q[$]);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    foreach (q[i]) begin
      c ^= {24'h000000, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
    end
    return ~c;
  endfunction : fcs
  // Build, send and judge one frame
  task automatic frame(input logic [47:0] da, input int n, input bit bad,
                       input bit wk, input logic [3:0] sfd, input int acc);
    logic [7:0] q[$];
    logic [31:0] c;
    int d0;
    for (int i = 5; i >= 0; i--) q.push_back(da[8*i+:8]);
    if (wk) begin
      repeat (6) q.push_back(8'hFF);
      repeat (16) for (int i = 5; i >= 0; i--)
        q.push_back(station_addr[8*i+:8]);
    end
    repeat (n) q.push_back(8'($random(seed)));
    c = fcs(q) ^ {32{bad}};
    for (int i = 0; i < 4; i++) q.push_back(c[8*i+:8]);
    got.delete();
    d0 = dones;
    i_phy.send(q, sfd);
    repeat (60) @(negedge mclk);
    chk(dones - d0, acc);
    if (acc && !wk) begin
      chk(got.size(), q.size() - 6);
      foreach (got[i]) chk(got[i], q[i+6]);
      chk({rx_frame_ok, rx_crc_error}, {!bad, bad});
    end
  endtask : frame
  // One management frame, bit by bit; the bench is the PHY on reads
  task automatic mgmt(input bit rd, input logic [4:0] pa,
                      input logic [4:0] ra, input logic [15:0] d);
    logic [63:0] v;
    bit rel;
    v = {32'hFFFFFFFF, 2'b01, rd ? 2'b10 : 2'b01, pa, ra, 2'b10, d};
    for (int i = 63; i >= 0; i--) begin
      rel = rd && i < 18;
      @(negedge mclk);
      pir_mdc_bit = 1'b0;
      pir_mdo_bit = v[i] ^ rel;
      pir_mmd_bit = !rel;
      phy_b = v[i];
      repeat (4) @(negedge mclk);
      chk({mdc, mdio_o, mdio_oe_n}, {1'b0, v[i] ^ rel, rel});
      chk(pir_mdi_bit, v[i]);
      pir_mdc_bit = 1'b1;
      repeat (2) @(negedge mclk);
      chk(mdc, 1'b1);
    end
    pir_mmd_bit = 1'b0;
    repeat (2) @(negedge mclk);
    chk(mdio_oe_n, 1'b1);
  endtask : mgmt
  task automatic end_of_test();
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  initial begin
    #900us;
    miscompares++;
    end_of_test();
  end
  // Main sequence
  initial begin
    seed = 67;
    {rst_n, rx_enable_bit, promiscuous_mode, multicast_enable} = '0;
    {soft_reset_bit, wake_detect_enable, wake_detect_irq_enable} = '0;
    {pir_mdc_bit, pir_mdo_bit, pir_mmd_bit, phy_b} = '0;
    station_addr = 48'h02A4C6E81357;
    repeat (4) @(negedge rx_clk);
    @(negedge mclk);
    rst_n = 1'b1;
    chk({rx_frame_ok, rx_crc_error, wake_irq, wake_pin, mdio_oe_n}, 5'h01);
    rx_enable_bit = 1'b1;
    repeat (8) @(negedge rx_clk);
    frame(station_addr, 1 + ($random(seed) & 15), 0, 0, 4'hD, 1);
    frame(station_addr, 5, 1, 0, 4'hD, 1);
    frame(48'h0A0B0C0D0E0F, 3, 0, 0, 4'hD, 0);
    frame(48'hFFFFFFFFFFFF, 3, 0, 0, 4'hD, 1);
    frame(48'h01005E000001, 3, 0, 0, 4'hD, 0);
    multicast_enable = 1'b1;
    frame(48'h01005E000001, 3, 0, 0, 4'hD, 1);
    promiscuous_mode = 1'b1;
    frame(48'h0A0B0C0D0E0F, 3, 0, 0, 4'hD, 1);
    {promiscuous_mode, multicast_enable} = 2'h0;
    frame(station_addr, 4, 0, 0, 4'h7, 0);
    rx_enable_bit = 1'b0;
    repeat (8) @(negedge rx_clk);
    frame(station_addr, 4, 0, 0, 4'hD, 0);
    rx_enable_bit = 1'b1;
    repeat (8) @(negedge rx_clk);
    frame(station_addr, 4, 0, 0, 4'hD, 1);
    for (int m = 0; m < 3; m++) begin
      @(negedge mclk);
      wake_detect_enable = m > 0;
      wake_detect_irq_enable = m > 1;
      repeat (8) @(negedge rx_clk);
      frame(48'h0A0B0C0D0E0F, 2, 0, 1, 4'hD, m > 0);
      chk({wake_pin, wake_irq}, {m > 0, m > 1});
      soft_reset_bit = 1'b1;
      repeat (4) @(negedge rx_clk);
      @(negedge mclk);
      soft_reset_bit = 1'b0;
      chk({wake_pin, wake_irq}, 2'h0);
      repeat (8) @(negedge rx_clk);
    end
    repeat (40) begin
      @(negedge mclk);
      {pir_mdc_bit, pir_mdo_bit, pir_mmd_bit, phy_b} = 4'($random(seed));
      @(negedge mclk);
      chk(mdc, pir_mdc_bit);
      chk({mdio_o, mdio_oe_n}, {pir_mdo_bit, !pir_mmd_bit});
      repeat (4) @(negedge mclk);
      chk(pir_mdi_bit, pir_mmd_bit ? pir_mdo_bit : phy_b);
    end
    mgmt(1'b0, 5'h01, 5'($random(seed)), 16'($random(seed)));
    mgmt(1'b1, 5'h01, 5'($random(seed)), 16'($random(seed)));
    end_of_test();
  end
endmodule : tb_top
